// *** logic/hvc_channel.sv ***
// single high-voltage channel control: setpoint select, ramps, trip timer,
// power gating and identification; the analog stage sits outside
// assumes adc readbacks and status pins arrive asynchronously
`timescale 1ns/1ns
`include "hvc_defs.svh"
module hvc_channel #(
  parameter int TICK_CYCLES = `HVC_TICK_CYCLES
) (
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic [7:0]        CLUSTER_NUM,
  input  wire logic [7:0]        SLOT_NUM,
  input  wire logic [7:0]        CHAN_NUM,
  input  wire logic [7:0]        ADDR,
  input  wire logic [15:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  input  wire logic              REMOTE,
  output logic      [15:0]       RDATA,
  input  wire logic              VOLTAGE_SELECT_IN,
  input  wire logic              CURRENT_SELECT_IN,
  input  wire logic              SAFETY_LOCKOUT,
  input  wire logic              OUTPUTS_ENABLED,
  input  wire logic              OVERCURRENT,
  input  wire logic              FIXED_PROTECTION,
  input  wire logic              POWERED_BEFORE,
  input  wire logic [15:0]       VOLTAGE_READBACK,
  input  wire logic [15:0]       CURRENT_READBACK,
  output logic      [15:0]       VOLTAGE_DRIVE,
  output logic      [15:0]       CURRENT_LIMIT_SETTING,
  output logic                   CURRENT_REGULATE,
  output logic                   OUTPUT_CUT,
  output logic                   POWER_STATE,
  output logic                   TRIP_STATUS,
  output logic                   CHANNEL_ACTIVE_OUT
);
  import hvc_pkg::*;

  typedef struct packed {
    logic [1:0]  voltage_select_in_s;
    logic [1:0]  current_select_in_s;
    logic [1:0]  lock_s;
    logic [1:0]  en_s;
    logic [1:0]  ovc_s;
    logic [1:0]  fix_s;
    logic [31:0] voltage_readback_s;
    logic [31:0] current_readback_s;
    logic        started;
    hvc_word_t   vset_a;
    hvc_word_t   vset_b;
    hvc_word_t   ilim_a;
    hvc_word_t   ilim_b;
    hvc_word_t   sw_ceil;
    hvc_word_t   rise;
    hvc_word_t   fall;
    hvc_word_t   trip;
    hvc_word_t   trip_cnt;
    logic        power;
    logic        restore;
    logic        ramp_dn;
    logic        tripped;
    logic        cut;
    hvc_state_e  state;
    hvc_word_t   vout;
    hvc_word_t   rdata;
    logic [`HVC_LABEL_LEN-1:0][7:0] label;
  } hvc_ch_s;

  hvc_ch_s st;
  hvc_ch_s next_st;

  hvc_tick_if tk ();

  hvc_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk   (CLK),
    .rst_b (RST_B),
    .tk    (tk)
  );

  function automatic logic label_ok(input logic [7:0] c);
    label_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
               (c >= 8'h61 && c <= 8'h7a) || c == 8'h23 || c == 8'h26 ||
               c == 8'h25 || c == 8'h24 || c == 8'h2a || c == 8'h5f ||
               c == 8'h2d || c == 8'h00;
  endfunction

  logic      voltage_select_in;
  logic      current_select_in;
  logic      lock;
  logic      en;
  logic      ovc;
  hvc_word_t target;
  logic      wr_ctrl;
  logic      pw_req;
  logic      clr;
  logic      trip_fire;
  logic      trip_mode;

  assign voltage_select_in = st.voltage_select_in_s[1];
  assign current_select_in = st.current_select_in_s[1];
  assign lock = st.lock_s[1];
  assign en   = st.en_s[1];
  assign ovc  = st.ovc_s[1];
  assign wr_ctrl = WR && ADDR == `HVC_A_CTRL;
  assign pw_req  = wr_ctrl && WDATA[`HVC_CTRL_PWR];
  assign clr     = wr_ctrl && WDATA[`HVC_CTRL_CLEAR];
  assign trip_mode = st.trip != 16'h0 && st.trip < `HVC_TRIP_FOREVER;
  assign trip_fire = trip_mode && ovc && st.state == HVC_ON && tk.tick &&
                     st.trip_cnt <= 16'h1;

  always_comb begin
    next_st = st;
    next_st.voltage_select_in_s = {st.voltage_select_in_s[0], VOLTAGE_SELECT_IN};
    next_st.current_select_in_s = {st.current_select_in_s[0], CURRENT_SELECT_IN};
    next_st.lock_s = {st.lock_s[0], SAFETY_LOCKOUT};
    next_st.en_s   = {st.en_s[0], OUTPUTS_ENABLED};
    next_st.ovc_s  = {st.ovc_s[0], OVERCURRENT};
    next_st.fix_s  = {st.fix_s[0], FIXED_PROTECTION};
    next_st.voltage_readback_s = {st.voltage_readback_s[15:0], VOLTAGE_READBACK};
    next_st.current_readback_s = {st.current_readback_s[15:0], CURRENT_READBACK};
    target = voltage_select_in ? st.vset_b : st.vset_a;

    // startup restore of the previous power state
    if (!st.started) begin
      next_st.started = 1'b1;
      next_st.power = st.restore && POWERED_BEFORE;
    end

    // register writes
    if (WR) begin
      if (ADDR == `HVC_A_VSET_A && WDATA <= st.sw_ceil) begin
        next_st.vset_a = WDATA;
      end else if (ADDR == `HVC_A_VSET_B && WDATA <= st.sw_ceil) begin
        next_st.vset_b = WDATA;
      end else if (ADDR == `HVC_A_ILIM_A) begin
        next_st.ilim_a = WDATA;
      end else if (ADDR == `HVC_A_ILIM_B) begin
        next_st.ilim_b = WDATA;
      end else if (ADDR == `HVC_A_SWCEIL) begin
        next_st.sw_ceil = WDATA;
      end else if (ADDR == `HVC_A_RISE) begin
        next_st.rise = WDATA;
      end else if (ADDR == `HVC_A_FALL) begin
        next_st.fall = WDATA;
      end else if (ADDR == `HVC_A_TRIP) begin
        next_st.trip = WDATA;
        next_st.trip_cnt = WDATA;
      end else if (ADDR == `HVC_A_CTRL) begin
        // a refused request never shows on the power state, not even for a cycle
        next_st.power = WDATA[`HVC_CTRL_PWR] && !lock && en;
        next_st.restore = WDATA[`HVC_CTRL_RESTORE];
        next_st.ramp_dn = WDATA[`HVC_CTRL_RAMPDN];
      end else if (ADDR >= `HVC_A_LABEL0 &&
                   ADDR < `HVC_A_LABEL0 + 8'(`HVC_LABEL_LEN) &&
                   REMOTE && label_ok(WDATA[7:0])) begin
        next_st.label[4'(ADDR - `HVC_A_LABEL0)] = WDATA[7:0];
      end
      // cluster, slot and channel addresses take no write
    end

    // power on write clears alarms and reloads the counter
    if (pw_req || clr) begin
      next_st.tripped = 1'b0;
      next_st.trip_cnt = st.trip;
    end

    // trip counter
    if (!ovc && !trip_fire) begin
      next_st.trip_cnt = (WR && ADDR == `HVC_A_TRIP) ? WDATA : st.trip;
    end else if (ovc && trip_mode && tk.tick && st.trip_cnt != 16'h0 &&
                 st.state == HVC_ON && !pw_req && !clr &&
                 !(WR && ADDR == `HVC_A_TRIP)) begin
      next_st.trip_cnt = st.trip_cnt - 16'h1;
    end

    // output state machine
    case (st.state)
      HVC_OFF: begin
        next_st.vout = 16'h0;
        next_st.cut = 1'b0;
        if (st.power && !lock && en && !st.tripped) begin
          next_st.state = HVC_ON;
        end else if (st.power && (lock || !en)) begin
          next_st.power = 1'b0;
        end
      end
      HVC_ON: begin
        if (trip_fire) begin
          next_st.tripped = 1'b1;
          next_st.power = 1'b0;
          if (st.ramp_dn) begin
            next_st.state = HVC_RAMPDN;
          end else begin
            next_st.vout = 16'h0;
            next_st.cut = 1'b1;
            next_st.state = HVC_OFF;
          end
        end else if (!st.power || lock || !en) begin
          next_st.power = st.power && !lock && en;
          next_st.state = HVC_RAMPDN;
        end else if (tk.tick && st.vout < target) begin
          next_st.vout = (target - st.vout > st.rise) ?
                         st.vout + st.rise : target;
        end else if (tk.tick && st.vout > target) begin
          next_st.vout = (st.vout - target > st.fall) ?
                         st.vout - st.fall : target;
        end
      end
      HVC_RAMPDN: begin
        if (tk.tick) begin
          next_st.vout = (st.vout > st.fall) ? st.vout - st.fall : 16'h0;
        end
        if (st.vout == 16'h0) begin
          next_st.state = HVC_OFF;
        end
      end
      default: begin
        next_st.state = HVC_OFF;
      end
    endcase

    // read port
    next_st.rdata = 16'h0;
    if (RD) begin
      if (ADDR == `HVC_A_CLUSTER) begin
        next_st.rdata = {8'h00, CLUSTER_NUM};
      end else if (ADDR == `HVC_A_SLOT) begin
        next_st.rdata = {8'h00, SLOT_NUM};
      end else if (ADDR == `HVC_A_CHAN) begin
        next_st.rdata = {8'h00, CHAN_NUM};
      end else if (ADDR == `HVC_A_VSET_A) begin
        next_st.rdata = st.vset_a;
      end else if (ADDR == `HVC_A_VSET_B) begin
        next_st.rdata = st.vset_b;
      end else if (ADDR == `HVC_A_ILIM_A) begin
        next_st.rdata = st.ilim_a;
      end else if (ADDR == `HVC_A_ILIM_B) begin
        next_st.rdata = st.ilim_b;
      end else if (ADDR == `HVC_A_SWCEIL) begin
        next_st.rdata = st.sw_ceil;
      end else if (ADDR == `HVC_A_RISE) begin
        next_st.rdata = st.rise;
      end else if (ADDR == `HVC_A_FALL) begin
        next_st.rdata = st.fall;
      end else if (ADDR == `HVC_A_TRIP) begin
        next_st.rdata = st.trip;
      end else if (ADDR == `HVC_A_CTRL) begin
        next_st.rdata = {13'h0, st.ramp_dn, st.restore, st.power};
      end else if (ADDR == `HVC_A_STATUS) begin
        next_st.rdata = {st.trip_cnt[10:0], st.state, 1'b0, st.tripped, ovc};
      end else if (ADDR == `HVC_A_VOLTAGE_READBACK) begin
        next_st.rdata = st.voltage_readback_s[31:16];
      end else if (ADDR == `HVC_A_CURRENT_READBACK) begin
        next_st.rdata = st.current_readback_s[31:16];
      end else if (ADDR == `HVC_A_VOUT) begin
        next_st.rdata = st.vout;
      end else if (ADDR >= `HVC_A_LABEL0 &&
                   ADDR < `HVC_A_LABEL0 + 8'(`HVC_LABEL_LEN)) begin
        next_st.rdata = {8'h00, st.label[4'(ADDR - `HVC_A_LABEL0)]};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st <= '0;
      st.trip <= `HVC_TRIP_FOREVER;
      st.trip_cnt <= `HVC_TRIP_FOREVER;
      st.sw_ceil <= `HVC_CEIL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA = st.rdata;
  assign VOLTAGE_DRIVE = st.vout;
  assign CURRENT_LIMIT_SETTING = current_select_in ? st.ilim_b : st.ilim_a;
  // programmable boards regulate under the limit; fixed ones run to hw maximum
  assign CURRENT_REGULATE = st.state == HVC_ON && ovc && !st.fix_s[1];
  assign OUTPUT_CUT = st.cut;
  assign POWER_STATE = st.power;
  assign TRIP_STATUS = st.tripped;
  assign CHANNEL_ACTIVE_OUT = st.power && en && st.state == HVC_ON;
endmodule

// *** logic/hvc_defs.svh ***
// timing and field constants of the hv channel control block
// included by the design modules and by the testbench
// Behaviour
// - channel address is read-only, built from cluster, slot and channel numbers.
// - channel label takes at most 11 allowed characters, written only remotely.
// - voltage select low picks setpoint a, high picks setpoint b.
// - current select low picks limit a, high picks limit b.
// - software voltage ceiling bounds any voltage setpoint that may be programmed.
// - rising toward a higher target goes no faster than the rise rate.
// - falling toward a lower target goes no faster than the fall rate.
// - ramp to zero at fall rate on power off, ramped trip, or outputs disabled.
// - timeout 1000 allows overcurrent forever, holding current under the selected limit.
// - fixed protection boards let current pass the limit up to hardware maximum.
// - timeout between 0 and 1000 limits current for that time, then shuts off.
// - reload counter on timeout write, alarm clear, power on, or overcurrent end.
// - counter decrements only during overcurrent, stops on reload or expiry.
// - power on takes effect only without lockout and with outputs enabled.
// - at turn-on the output rises from 0 to selected setpoint at rise rate.
// - writing power on clears alarms and reloads the timeout counter.
// - at start restore previous power state if restore enabled, else stay off; reset clears the restore flag, so the code always starts off.
// - trip shutdown cuts off at once or ramps down per shutdown style.
// - voltage and current readbacks are readable by local and remote parties.
// - trip status sets on overcurrent trip, clears on power on or alarm clear.
// - channel active output is high while enabled, power state on and the output state machine in the on state.
`ifndef HVC_DEFS_SVH
`define HVC_DEFS_SVH
`define HVC_CLK_HZ        20000000
`define HVC_TICK_HZ       1000
`define HVC_TICK_CYCLES   (`HVC_CLK_HZ / `HVC_TICK_HZ)
`define HVC_TRIP_FOREVER  16'h03e8
`define HVC_LABEL_LEN     11
`define HVC_CEIL_RESET    16'hffff
`define HVC_A_CLUSTER     8'h00
`define HVC_A_SLOT        8'h01
`define HVC_A_CHAN        8'h02
`define HVC_A_VSET_A      8'h03
`define HVC_A_VSET_B      8'h04
`define HVC_A_ILIM_A      8'h05
`define HVC_A_ILIM_B      8'h06
`define HVC_A_SWCEIL      8'h07
`define HVC_A_RISE        8'h08
`define HVC_A_FALL        8'h09
`define HVC_A_TRIP        8'h0a
`define HVC_A_CTRL        8'h0b
`define HVC_A_STATUS      8'h0c
`define HVC_A_VOLTAGE_READBACK        8'h0d
`define HVC_A_CURRENT_READBACK        8'h0e
`define HVC_A_VOUT        8'h0f
`define HVC_A_LABEL0      8'h10
`define HVC_CTRL_PWR      0
`define HVC_CTRL_RESTORE  1
`define HVC_CTRL_RAMPDN   2
`define HVC_CTRL_CLEAR    3
`endif

// *** logic/hvc_pkg.sv ***
// types of the hv channel control block
// constants live in hvc_defs.svh
package hvc_pkg;
  typedef enum logic [1:0] {HVC_OFF, HVC_ON, HVC_RAMPDN} hvc_state_e;
  typedef logic [15:0] hvc_word_t;
endpackage

// *** logic/hvc_tick.sv ***
// timebase divider: one-cycle tick every cycles clock periods
// assumes a single free-running clock
`timescale 1ns/1ns
`include "hvc_defs.svh"
module hvc_tick #(
  parameter int CYCLES = `HVC_TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  hvc_tick_if.src         tk
);
  import hvc_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } hvc_tick_s;
  hvc_tick_s st;
  hvc_tick_s next_st;
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= 32'(CYCLES - 1)) begin
      next_st.cnt = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tk.tick = st.tick;
endmodule

// *** logic/hvc_tick_if.sv ***
// carrier of the timebase tick between the ramp core and the divider
// both ends run on the same clock
`timescale 1ns/1ns
interface hvc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// *** testbench/hvc_channel_checker.sv ***
// port assertions for one high-voltage channel controller
// bound to hvc_channel; one clock, synchronous active-low reset
`timescale 1ns/1ns
module hvc_channel_checker #(
  parameter int TICK_CYCLES = 20000
) (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        RD,
  input wire logic        WR,
  input wire logic        SAFETY_LOCKOUT,
  input wire logic        OUTPUTS_ENABLED,
  input wire logic        FIXED_PROTECTION,
  input wire logic [15:0] RDATA,
  input wire logic [15:0] VOLTAGE_DRIVE,
  input wire logic        CURRENT_REGULATE,
  input wire logic        OUTPUT_CUT,
  input wire logic        POWER_STATE,
  input wire logic        TRIP_STATUS,
  input wire logic        CHANNEL_ACTIVE_OUT
);
  logic [15:0] since;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // cycles since the drive last went up
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      since <= 16'hffff;
    end else if (VOLTAGE_DRIVE > $past(VOLTAGE_DRIVE)) begin
      since <= 16'h0000;
    end else if (since != 16'hffff) begin
      since <= since + 16'h0001;
    end
  end
  property p_rise;
    VOLTAGE_DRIVE > $past(VOLTAGE_DRIVE) |-> since >= TICK_CYCLES - 1;
  endproperty
  a_rise: assert property (p_rise)
    else $error("drive rose twice in one tick");
  property p_rd;
    RDATA != 16'h0000 |-> $past(RD);
  endproperty
  a_rd: assert property (p_rd)
    else $error("read data without read");
  property p_lock;
    (SAFETY_LOCKOUT || !OUTPUTS_ENABLED) [*4] |=> !$rose(POWER_STATE);
  endproperty
  a_lock: assert property (p_lock)
    else $error("power on while gated");
  property p_gate;
    (SAFETY_LOCKOUT || !OUTPUTS_ENABLED) [*6] |-> !POWER_STATE;
  endproperty
  a_gate: assert property (p_gate)
    else $error("power kept while gated");
  property p_act;
    CHANNEL_ACTIVE_OUT |-> POWER_STATE;
  endproperty
  a_act: assert property (p_act)
    else $error("active without power");
  property p_trip;
    $rose(TRIP_STATUS) |-> ##[0:2] !POWER_STATE;
  endproperty
  a_trip: assert property (p_trip)
    else $error("trip left power on");
  property p_kill;
    OUTPUT_CUT |-> ##[0:1] VOLTAGE_DRIVE == 16'h0000;
  endproperty
  a_kill: assert property (p_kill)
    else $error("cut left drive up");
  property p_clr;
    $fell(TRIP_STATUS) |-> $past(WR) || $past(WR, 2);
  endproperty
  a_clr: assert property (p_clr)
    else $error("trip cleared without write");
  property p_fix;
    FIXED_PROTECTION [*3] |-> !CURRENT_REGULATE;
  endproperty
  a_fix: assert property (p_fix)
    else $error("regulating on fixed board");
  property p_pon;
    $rose(POWER_STATE) |-> ##[0:1] !TRIP_STATUS;
  endproperty
  a_pon: assert property (p_pon)
    else $error("power on kept trip");
  c_trip: cover property ($rose(TRIP_STATUS));
  c_cut: cover property (OUTPUT_CUT);
  c_reg: cover property (CURRENT_REGULATE);
endmodule
bind hvc_channel hvc_channel_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .CLK(CLK), .RST_B(RST_B), .RD(RD), .WR(WR), .SAFETY_LOCKOUT(SAFETY_LOCKOUT),
  .OUTPUTS_ENABLED(OUTPUTS_ENABLED), .FIXED_PROTECTION(FIXED_PROTECTION),
  .RDATA(RDATA), .VOLTAGE_DRIVE(VOLTAGE_DRIVE), .CURRENT_REGULATE(CURRENT_REGULATE),
  .OUTPUT_CUT(OUTPUT_CUT), .POWER_STATE(POWER_STATE), .TRIP_STATUS(TRIP_STATUS),
  .CHANNEL_ACTIVE_OUT(CHANNEL_ACTIVE_OUT));

// *** testbench/hvc_stage_model.sv ***
// behavioural high-voltage output stage facing one channel controller
// assumes the bench sets the load current demand
`timescale 1ns/1ns
module hvc_stage_model
  import hvc_pkg::*;
(
  input  wire logic [15:0] drive,
  input  wire logic [15:0] limit,
  input  wire logic        regulate,
  input  wire logic [15:0] demand,
  output hvc_pkg::hvc_word_t voltage_readback,
  output hvc_pkg::hvc_word_t current_readback,
  output logic             ovc
);
  assign voltage_readback = drive;
  // regulation clamps the current at the limit, otherwise the load wins
  assign current_readback = regulate ? limit : demand;
  assign ovc  = demand > limit;
endmodule

// *** testbench/tb_hv_channel_control.sv ***
// self-checking bench for one high-voltage channel controller
// drives the register port and pins, output stage is a model
`timescale 1ns/1ns
`include "hvc_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_hv_channel_control;
  import hvc_pkg::*;
  logic       clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, remote = 1'b1;
  logic       voltage_select_in = 1'b0, current_select_in = 1'b0, lock = 1'b0, en = 1'b1, fixp = 1'b0;
  logic       pwb = 1'b1, rd_d = 1'b0, ovc, creg, cut, pwr, trip, act;
  logic [7:0] addr = 8'h00;
  hvc_word_t  wdata = 16'h0000, demand = 16'h0000, rdata, vrb, crb, vdrv, ilim;
  hvc_word_t  q[$], exp_v, va, vb, lf = 16'h000d;
  int         miscompares = 0, comparisons = 0, n;
  always #25 clk = ~clk;
  hvc_channel #(.TICK_CYCLES(4)) dut_u (
    .CLK(clk), .RST_B(rst_b), .CLUSTER_NUM(8'h01), .SLOT_NUM(8'h05),
    .CHAN_NUM(8'h03), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .REMOTE(remote), .RDATA(rdata), .VOLTAGE_SELECT_IN(voltage_select_in),
    .CURRENT_SELECT_IN(current_select_in), .SAFETY_LOCKOUT(lock), .OUTPUTS_ENABLED(en),
    .OVERCURRENT(ovc), .FIXED_PROTECTION(fixp), .POWERED_BEFORE(pwb),
    .VOLTAGE_READBACK(vrb), .CURRENT_READBACK(crb), .VOLTAGE_DRIVE(vdrv),
    .CURRENT_LIMIT_SETTING(ilim), .CURRENT_REGULATE(creg), .OUTPUT_CUT(cut),
    .POWER_STATE(pwr), .TRIP_STATUS(trip), .CHANNEL_ACTIVE_OUT(act));
  hvc_stage_model stage_u (.drive(vdrv), .limit(ilim), .regulate(creg),
    .demand(demand), .voltage_readback(vrb), .current_readback(crb), .ovc(ovc));
  function automatic hvc_word_t lfsr(input hvc_word_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input hvc_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input hvc_word_t e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      exp_v = q.pop_front();
      `CHK(rdata, exp_v)
    end
    rd_d <= rd;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    wr_reg(`HVC_A_SLOT, 16'h00ff);
    `CHK(pwr, 1'b0)
    rd_reg(`HVC_A_CLUSTER, 16'h0001);
    rd_reg(`HVC_A_SLOT, 16'h0005);
    rd_reg(`HVC_A_CHAN, 16'h0003);
    rd_reg(`HVC_A_TRIP, `HVC_TRIP_FOREVER);
    rd_reg(`HVC_A_SWCEIL, 16'hffff);
    rd_reg(8'h7f, 16'h0000);
    wr_reg(`HVC_A_LABEL0, 16'h0041);
    wr_reg(`HVC_A_LABEL0, 16'h0021);
    remote <= 1'b0;
    wr_reg(`HVC_A_LABEL0, 16'h0042);
    remote <= 1'b1;
    wr_reg(`HVC_A_LABEL0 + 8'h0a, 16'h002d);
    rd_reg(`HVC_A_LABEL0, 16'h0041);
    rd_reg(`HVC_A_LABEL0 + 8'h0a, 16'h002d);
    wr_reg(`HVC_A_SWCEIL, 16'h0100);
    wr_reg(`HVC_A_VSET_A, 16'h0101);
    rd_reg(`HVC_A_VSET_A, 16'h0000);
    lf = lfsr(lf);
    va = 16'h0020 + (lf & 16'h001f);
    vb = va + 16'h0040;
    wr_reg(`HVC_A_VSET_A, va);
    wr_reg(`HVC_A_VSET_B, vb);
    wr_reg(`HVC_A_ILIM_A, 16'h0010);
    wr_reg(`HVC_A_ILIM_B, 16'h0020);
    wr_reg(`HVC_A_RISE, 16'h0010);
    wr_reg(`HVC_A_FALL, 16'h0008);
    for (int i = 0; i < 2; i++) begin
      current_select_in <= i[0];
      repeat (4) @(posedge clk);
      `CHK(ilim, i ? 16'h0020 : 16'h0010)
    end
    lock <= 1'b1;
    voltage_select_in <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(`HVC_A_CTRL, 16'h0001);
    repeat (4) @(posedge clk);
    `CHK(pwr, 1'b0)
    lock <= 1'b0;
    repeat (4) @(posedge clk);
    wr_reg(`HVC_A_CTRL, 16'h0001);
    `CHK(vdrv, 16'h0000)
    for (n = 0; n < 200 && vdrv !== vb; n++) @(posedge clk);
    `CHK(vdrv, vb)
    `CHK(act, 1'b1)
    rd_reg(`HVC_A_VOLTAGE_READBACK, vb);
    voltage_select_in <= 1'b0;
    for (n = 0; n < 200 && vdrv !== va; n++) @(posedge clk);
    `CHK(vdrv, va)
    wr_reg(`HVC_A_TRIP, 16'h0005);
    // bursts shorter than the timeout must each restart the count
    for (int i = 0; i < 3; i++) begin
      demand <= 16'h0040;
      repeat (8) @(posedge clk);
      demand <= 16'h0000;
      repeat (4) @(posedge clk);
    end
    `CHK(trip, 1'b0)
    for (int s = 0; s < 2; s++) begin
      wr_reg(`HVC_A_CTRL, s ? 16'h0005 : 16'h0001);
      @(posedge clk);
      `CHK(trip, 1'b0)
      demand <= 16'h0040;
      for (n = 0; n < 100 && trip !== 1'b1; n++) @(posedge clk);
      `CHK(trip, 1'b1)
      `CHK(cut, !s[0])
      demand <= 16'h0000;
      repeat (2) @(posedge clk);
      `CHK(pwr, 1'b0)
      `CHK(vdrv !== 16'h0000, s[0])
      for (n = 0; n < 200 && vdrv !== 16'h0000; n++) @(posedge clk);
      `CHK(vdrv, 16'h0000)
    end
    wr_reg(`HVC_A_CTRL, 16'h0008);
    @(posedge clk);
    `CHK(trip, 1'b0)
    wr_reg(`HVC_A_TRIP, `HVC_TRIP_FOREVER);
    wr_reg(`HVC_A_CTRL, 16'h0001);
    demand <= 16'h0040;
    repeat (60) @(posedge clk);
    `CHK(trip, 1'b0)
    `CHK(creg, 1'b1)
    rd_reg(`HVC_A_CURRENT_READBACK, 16'h0020);
    fixp <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(creg, 1'b0)
    rd_reg(`HVC_A_CURRENT_READBACK, 16'h0040);
    demand <= 16'h0000;
    en <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(pwr, 1'b0)
    `CHK(act, 1'b0)
    for (n = 0; n < 200 && vdrv !== 16'h0000; n++) @(posedge clk);
    `CHK(vdrv, 16'h0000)
    en <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(`HVC_A_CTRL, 16'h0003);
    repeat (2) @(posedge clk);
    `CHK(pwr, 1'b1)
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(pwr, 1'b0)
    summarize();
  end
endmodule
